// ==== ifsc_consts.svh ====
// constants for the instruction field and state control block
`ifndef IFSC_CONSTS_SVH
`define IFSC_CONSTS_SVH
`define IFSC_ADDR_CTRL     32'h0000_0000
`define IFSC_ADDR_STATE    32'h0000_0004
`define IFSC_ADDR_INSTR_HI 32'h0000_0008
`define IFSC_ADDR_INSTR_LO 32'h0000_000c
`define IFSC_ADDR_FIELDS0  32'h0000_0010
`define IFSC_ADDR_FIELDS1  32'h0000_0014
`define IFSC_ADDR_BASEVAL  32'h0000_0018
`define IFSC_ADDR_INDEXVAL 32'h0000_001c
`define IFSC_ADDR_EADDR    32'h0000_0020
`define IFSC_ADDR_OPADDR   32'h0000_0024
`define IFSC_ADDR_IRQSTAT  32'h0000_0028
`define IFSC_ADDR_IRQMASK  32'h0000_002c
`define IFSC_CTRL_ASCII    0
`define IFSC_CTRL_RET_LO   1
`define IFSC_CTRL_RET_HI   2
`define IFSC_CTRL_RETURN   3
`define IFSC_IRQ_STATECHG  0
`define IFSC_IRQ_MISALIGN  1
`define IFSC_IRQ_NOTE_BITS 2
`define IFSC_ADDR_BITS     24
`define IFSC_BYTE_BITS     8
`endif

// ==== ifsc_pkg.sv ====
// types of the instruction field and state control block
package ifsc_pkg;
  typedef enum logic [1:0] {
    IFSC_USER_PROBLEM_STATE      = 2'b00,
    IFSC_DISPATCHED_TASK_STATE   = 2'b01,
    IFSC_INTERRUPT_CONTROL_STATE = 2'b11,
    IFSC_MACHINE_CHECK_STATE     = 2'b10
  } ifsc_state_t;
  typedef enum logic [2:0] {
    IFSC_REG_REG_FORMAT       = 3'd0,
    IFSC_REG_INDEXED_FORMAT   = 3'd1,
    IFSC_REG_STORAGE_FORMAT   = 3'd2,
    IFSC_STORAGE_IMM_FORMAT   = 3'd3,
    IFSC_STORAGE_STOR_FORMAT  = 3'd4
  } ifsc_fmt_t;
  typedef enum logic [1:0] {
    IFSC_SIZE_BYTE = 2'd0,
    IFSC_SIZE_HALF = 2'd1,
    IFSC_SIZE_WORD = 2'd2,
    IFSC_SIZE_DBL  = 2'd3
  } ifsc_size_t;
  typedef struct packed {
    ifsc_fmt_t   fmt;
    logic [3:0]  firstOperandRegField;
    logic [3:0]  secondOperandRegField;
    logic [3:0]  thirdOperandRegField;
    logic [3:0]  indexRegField;
    logic [3:0]  firstBaseField;
    logic [3:0]  secondBaseField;
    logic [11:0] firstDispField;
    logic [11:0] secondDispField;
    logic [7:0]  immediateField;
    logic [3:0]  firstShortLenField;
    logic [3:0]  secondShortLenField;
    logic [7:0]  longLenField;
  } ifsc_fields_t;
  typedef struct packed {
    logic        dataPhase;
    logic        wrPend;
    logic [5:0]  wrAddr;
    logic        rdPend;
    logic [5:0]  rdAddr;
    logic [31:0] rdata;
    ifsc_state_t state;
    ifsc_state_t savedState;
    logic        asciiMode;
    logic [15:0] instrHi;
    logic [31:0] instrLo;
    ifsc_fields_t fields;
    logic [31:0] baseVal;
    logic [31:0] indexVal;
    logic [23:0] effAddr;
    logic [23:0] opAddr;
    ifsc_size_t  opSize;
    logic        misaligned;
    logic [1:0]  irqStat;
    logic [1:0]  irqMask;
    logic        irq;
    logic [1:0]  activeState;
    logic        charAscii;
  } ifsc_regs_t;
endpackage

// ==== ifsc_instr_field_ctrl.sv ====
// instruction field decoder and processor state control with an ahb-lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "ifsc_consts.svh"

// Overview of operation
// RULE1: four states, private registers, shared floating point
// RULE2: ordinary interrupt enters interrupt control state
// RULE3: machine check or power failure enters state four
// RULE4: user state normal; program decides follow-up
// RULE5: byte is eight bits, parity on io
// RULE6: halfword operand address multiple of two
// RULE7: word operand address multiple of four
// RULE8: doubleword operand address multiple of eight
// RULE9: memory addressable down to single bytes
// RULE10: program selects ebcdic or usascii code
// RULE11: decode five instruction formats
// RULE12: extract register, displacement, immediate, length fields
// RULE13: address is base plus index plus displacement
// RULE14: register zero field contributes zero term
// RULE15: field positions follow conventional layout
module ifsc_instr_field_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        intReq,
  input  wire logic        machineCheck,
  input  wire logic        powerFail,
  output logic [1:0]       activeState,
  output logic             charAscii,
  output logic             irqOut
);
  import ifsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: event inputs arrive from outside the clock domain
  logic [2:0] evMeta_q;
  logic [2:0] evSync_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      evMeta_q <= 3'h0;
      evSync_q <= 3'h0;
    end else begin
      evMeta_q <= {powerFail, machineCheck, intReq};
      evSync_q <= evMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // combinational decode of the held instruction
  ifsc_regs_t r_q;
  ifsc_regs_t r_d;
  ifsc_fields_t fDec;
  logic [7:0]  opcode;
  logic [23:0] eaSum;
  logic [23:0] baseTerm;
  logic [23:0] indexTerm;
  logic [3:0]  baseSel;
  logic [11:0] dispSel;
  logic        alignBad;

  always_comb begin
    opcode = r_q.instrHi[15:8];
    fDec = '0;
    // conventional layout: first halfword opcode plus two nibbles
    fDec.firstOperandRegField  = r_q.instrHi[7:4]; // RULE15
    fDec.secondOperandRegField = r_q.instrHi[3:0];
    fDec.thirdOperandRegField  = r_q.instrHi[3:0];
    fDec.indexRegField         = r_q.instrHi[3:0];
    fDec.immediateField        = r_q.instrHi[7:0]; // RULE12 RULE5
    fDec.longLenField          = r_q.instrHi[7:0];
    fDec.firstShortLenField    = r_q.instrHi[7:4];
    fDec.secondShortLenField   = r_q.instrHi[3:0];
    fDec.firstBaseField        = r_q.instrLo[31:28];
    fDec.firstDispField        = r_q.instrLo[27:16];
    fDec.secondBaseField       = r_q.instrLo[31:28];
    fDec.secondDispField       = r_q.instrLo[27:16];
    // opcode top two bits select the format; 10 splits on bit 5 for rs/si
    unique case (opcode[7:6])
      2'b00: fDec.fmt = IFSC_REG_REG_FORMAT; // RULE11
      2'b01: fDec.fmt = IFSC_REG_INDEXED_FORMAT;
      2'b10: fDec.fmt = opcode[5] ? IFSC_STORAGE_IMM_FORMAT : IFSC_REG_STORAGE_FORMAT;
      2'b11: fDec.fmt = IFSC_STORAGE_STOR_FORMAT;
    endcase
    if (fDec.fmt == IFSC_STORAGE_STOR_FORMAT) begin
      fDec.secondBaseField = r_q.instrLo[15:12];
      fDec.secondDispField = r_q.instrLo[11:0];
    end
    // address of the second operand (for si, of the first operand from the first base)
    baseSel = (fDec.fmt == IFSC_STORAGE_IMM_FORMAT) ? fDec.firstBaseField
                                                    : fDec.secondBaseField;
    dispSel = (fDec.fmt == IFSC_STORAGE_IMM_FORMAT) ? fDec.firstDispField
                                                    : fDec.secondDispField;
    baseTerm  = (baseSel == 4'h0) ? 24'h0 : r_q.baseVal[23:0]; // RULE14
    indexTerm = (fDec.fmt != IFSC_REG_INDEXED_FORMAT || fDec.indexRegField == 4'h0)
                ? 24'h0 : r_q.indexVal[23:0]; // RULE14
    eaSum = baseTerm + indexTerm + {12'h0, dispSel}; // RULE13
    // operand size boundaries; byte needs none since bytes are the unit
    unique case (r_q.opSize)
      IFSC_SIZE_BYTE: alignBad = 1'b0; // RULE9
      IFSC_SIZE_HALF: alignBad = r_q.opAddr[0]; // RULE6
      IFSC_SIZE_WORD: alignBad = |r_q.opAddr[1:0]; // RULE7
      IFSC_SIZE_DBL:  alignBad = |r_q.opAddr[2:0]; // RULE8
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic: bus slave, state control, interrupts
  logic        addrTake;
  logic [31:0] rdMux;
  logic [1:0]  irqEv;
  always_comb begin
    r_d = r_q;
    addrTake = hsel && hready && htrans[1];
    r_d.dataPhase = addrTake;
    r_d.wrPend = addrTake && hwrite;
    r_d.rdPend = addrTake && !hwrite;
    r_d.wrAddr = haddr[7:2];
    r_d.rdAddr = haddr[7:2];
    r_d.fields = fDec;
    r_d.effAddr = eaSum;
    r_d.misaligned = alignBad;
    irqEv = 2'h0;
    // state switching: machine check outranks ordinary interrupts
    if (evSync_q[1] || evSync_q[2]) begin
      if (r_q.state != IFSC_MACHINE_CHECK_STATE) begin
        r_d.savedState = r_q.state;
        irqEv[`IFSC_IRQ_STATECHG] = 1'b1;
      end
      r_d.state = IFSC_MACHINE_CHECK_STATE; // RULE3
    end else if (evSync_q[0] && r_q.state != IFSC_INTERRUPT_CONTROL_STATE
                 && r_q.state != IFSC_MACHINE_CHECK_STATE) begin
      r_d.savedState = r_q.state;
      r_d.state = IFSC_INTERRUPT_CONTROL_STATE; // RULE2
      irqEv[`IFSC_IRQ_STATECHG] = 1'b1;
    end else if (r_q.wrPend && r_q.wrAddr == 6'(`IFSC_ADDR_CTRL >> 2)
                 && hwdata[`IFSC_CTRL_RETURN]) begin
      // program decides where to go next; hardware only obeys
      r_d.state = ifsc_state_t'(hwdata[`IFSC_CTRL_RET_HI:`IFSC_CTRL_RET_LO]); // RULE4
    end
    if (alignBad && !r_q.misaligned)
      irqEv[`IFSC_IRQ_MISALIGN] = 1'b1;
    // register writes
    if (r_q.wrPend) begin
      unique case ({24'h0, r_q.wrAddr, 2'b00})
        `IFSC_ADDR_CTRL:     r_d.asciiMode = hwdata[`IFSC_CTRL_ASCII]; // RULE10
        `IFSC_ADDR_INSTR_HI: r_d.instrHi = hwdata[15:0];
        `IFSC_ADDR_INSTR_LO: r_d.instrLo = hwdata;
        `IFSC_ADDR_BASEVAL:  r_d.baseVal = hwdata;
        `IFSC_ADDR_INDEXVAL: r_d.indexVal = hwdata;
        `IFSC_ADDR_OPADDR: begin
          r_d.opAddr = hwdata[23:0];
          r_d.opSize = ifsc_size_t'(hwdata[25:24]);
        end
        `IFSC_ADDR_IRQMASK:  r_d.irqMask = hwdata[1:0];
        default: ;
      endcase
    end
    // read mux; reading status clears it but new events win
    unique case ({24'h0, r_d.rdAddr, 2'b00})
      `IFSC_ADDR_CTRL:     rdMux = {31'h0, r_q.asciiMode};
      `IFSC_ADDR_STATE:    rdMux = {28'h0, r_q.savedState, r_q.state};
      `IFSC_ADDR_INSTR_HI: rdMux = {16'h0, r_q.instrHi};
      `IFSC_ADDR_INSTR_LO: rdMux = r_q.instrLo;
      `IFSC_ADDR_FIELDS0:  rdMux = {1'b0, r_q.fields.fmt, r_q.fields.firstOperandRegField,
                                    r_q.fields.secondOperandRegField,
                                    r_q.fields.indexRegField, r_q.fields.immediateField,
                                    r_q.fields.firstShortLenField,
                                    r_q.fields.secondShortLenField};
      `IFSC_ADDR_FIELDS1:  rdMux = {r_q.fields.firstBaseField, r_q.fields.firstDispField,
                                    r_q.fields.secondBaseField, r_q.fields.secondDispField};
      `IFSC_ADDR_BASEVAL:  rdMux = r_q.baseVal;
      `IFSC_ADDR_INDEXVAL: rdMux = r_q.indexVal;
      `IFSC_ADDR_EADDR:    rdMux = {8'h0, r_q.effAddr};
      `IFSC_ADDR_OPADDR:   rdMux = {5'h0, r_q.misaligned, r_q.opSize, r_q.opAddr};
      `IFSC_ADDR_IRQSTAT:  rdMux = {30'h0, r_q.irqStat};
      `IFSC_ADDR_IRQMASK:  rdMux = {30'h0, r_q.irqMask};
      default:             rdMux = 32'h0;
    endcase
    r_d.rdata = addrTake && !hwrite ? rdMux : 32'h0;
    // a read clears only the bits it reported; an event landing while the
    // read is in flight is kept for the next read instead of being lost
    r_d.irqStat = r_q.irqStat;
    if (r_q.rdPend && r_q.rdAddr == 6'(`IFSC_ADDR_IRQSTAT >> 2))
      r_d.irqStat = r_q.irqStat & ~r_q.rdata[1:0];
    r_d.irqStat = r_d.irqStat | irqEv;
    r_d.irq = |(r_d.irqStat & r_d.irqMask);
    r_d.activeState = r_d.state; // RULE1
    r_d.charAscii = r_d.asciiMode;
  end

  ////////////////////////////////////////////////////////////////////////////
  // the single state register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r_q <= '0;
      r_q.state <= IFSC_USER_PROBLEM_STATE; // RULE4
      r_q.savedState <= IFSC_USER_PROBLEM_STATE;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs come from flip-flops; slave is zero wait, always okay
  assign hrdata      = r_q.rdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign activeState = r_q.activeState;
  assign charAscii   = r_q.charAscii;
  assign irqOut      = r_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // state control
  a_mchk_enter: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE3
    (evSync_q[1] || evSync_q[2]) |=> r_q.state == IFSC_MACHINE_CHECK_STATE)
    else $error("machine check did not enter state four");
  a_mchk_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE3
    (r_q.state == IFSC_MACHINE_CHECK_STATE && evSync_q[0]
     && !(r_q.wrPend && r_q.wrAddr == 6'(`IFSC_ADDR_CTRL >> 2)))
    |=> r_q.state == IFSC_MACHINE_CHECK_STATE)
    else $error("ordinary interrupt left machine check state");
  a_int_enter: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE2
    (evSync_q[0] && !evSync_q[1] && !evSync_q[2]
     && r_q.state inside {IFSC_USER_PROBLEM_STATE, IFSC_DISPATCHED_TASK_STATE})
    |=> r_q.state == IFSC_INTERRUPT_CONTROL_STATE)
    else $error("interrupt did not enter control state");
  // a state is kept until an event or a program-directed return moves it
  a_active_out: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE1
    $changed(activeState) |-> $past(evSync_q != 3'h0) || $past(r_q.wrPend))
    else $error("active state moved without a cause");
  a_prog_return: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE4
    (r_q.wrPend && r_q.wrAddr == 6'(`IFSC_ADDR_CTRL >> 2)
     && hwdata[`IFSC_CTRL_RETURN] && evSync_q == 3'h0)
    |=> r_q.state == $past(hwdata[`IFSC_CTRL_RET_HI:`IFSC_CTRL_RET_LO]))
    else $error("program-directed return ignored");
  // operand boundaries
  a_half_align: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE6
    (r_q.opSize == IFSC_SIZE_HALF && r_q.opAddr[0]) |=> r_q.misaligned)
    else $error("odd halfword not flagged");
  a_half_ok: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE6
    (r_q.opSize == IFSC_SIZE_HALF && !r_q.opAddr[0]) |=> !r_q.misaligned)
    else $error("even halfword flagged");
  a_word_align: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE7
    (r_q.opSize == IFSC_SIZE_WORD && r_q.opAddr[1:0] == 2'h0) |=> !r_q.misaligned)
    else $error("aligned word flagged");
  a_word_bad: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE7
    (r_q.opSize == IFSC_SIZE_WORD && r_q.opAddr[1:0] != 2'h0) |=> r_q.misaligned)
    else $error("offset word not flagged");
  a_dbl_align: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE8
    (r_q.opSize == IFSC_SIZE_DBL && r_q.opAddr[2:0] == 3'h4) |=> r_q.misaligned)
    else $error("doubleword boundary not checked");
  a_dbl_ok: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE8
    (r_q.opSize == IFSC_SIZE_DBL && r_q.opAddr[2:0] == 3'h0) |=> !r_q.misaligned)
    else $error("aligned doubleword flagged");
  a_byte_align: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE9
    (r_q.opSize == IFSC_SIZE_BYTE) |=> !r_q.misaligned)
    else $error("byte access flagged");
  // address adder
  a_ea_zero: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE14
    (fDec.fmt == IFSC_REG_INDEXED_FORMAT && fDec.secondBaseField == 4'h0
     && fDec.indexRegField == 4'h0) |=> r_q.effAddr == {12'h0, $past(fDec.secondDispField)})
    else $error("register zero term not zero");
  a_ea_sum: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE13
    (fDec.fmt == IFSC_REG_INDEXED_FORMAT && fDec.secondBaseField != 4'h0
     && fDec.indexRegField != 4'h0) |=> r_q.effAddr == 24'($past(r_q.baseVal[23:0])
     + $past(r_q.indexVal[23:0]) + {12'h0, $past(fDec.secondDispField)}))
    else $error("effective address sum wrong");
  // decode and outputs
  a_code_sel: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE10
    (r_q.wrPend && r_q.wrAddr == 6'(`IFSC_ADDR_CTRL >> 2))
    |=> charAscii == $past(hwdata[`IFSC_CTRL_ASCII]))
    else $error("character code output stale");
  a_fmt_decode: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE11
    (r_q.instrHi[15:14] == 2'b11) |=> r_q.fields.fmt == IFSC_STORAGE_STOR_FORMAT)
    else $error("storage-storage format missed");
  a_ss_fields: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE15
    (r_q.instrHi[15:14] == 2'b11)
    |=> r_q.fields.secondBaseField == $past(r_q.instrLo[15:12])
     && r_q.fields.secondDispField == $past(r_q.instrLo[11:0]))
    else $error("second operand fields misplaced");
  a_field_pick: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE12
    1'b1 |=> r_q.fields.immediateField == $past(r_q.instrHi[7:0])
     && r_q.fields.indexRegField == $past(r_q.instrHi[3:0]))
    else $error("register or immediate field misplaced");
  // bus and interrupts
  a_rd_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !r_q.rdPend |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  a_stat_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (irqEv != 2'h0) |=> (r_q.irqStat & $past(irqEv)) == $past(irqEv))
    else $error("status event lost against a clear");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
    irqOut == |(r_q.irqStat & r_q.irqMask))
    else $error("interrupt output mismatch");
endmodule
`default_nettype wire

// ==== ifsc_gpr_model.sv ====
// general register file model that supplies base and index contents
`timescale 1ns/1ns
`default_nettype none
module ifsc_gpr_model (
  input  wire logic [1:0]  stateSel,
  input  wire logic [3:0]  baseSel,
  input  wire logic [3:0]  idxSel,
  output logic      [31:0] baseData,
  output logic      [31:0] idxData
);
  logic [31:0] bank [4][16];
  ////////////////////////////////////////
  // one bank per state; register zero is nonzero so a zero term shows
  initial begin
    for (int s = 0; s < 4; s++) begin
      for (int r = 0; r < 16; r++) begin
        bank[s][r] = {8'hab, r[3:0], s[3:0], 16'hfff0};
      end
    end
  end
  // reads follow the active state, each state sees only its own bank
  assign baseData = bank[stateSel][baseSel];
  assign idxData  = bank[stateSel][idxSel];
endmodule
`default_nettype wire

// ==== ifsc_instr_field_ctrl_bench.sv ====
// self-checking bench for the instruction field and state control block
`timescale 1ns/1ns
`default_nettype none
`include "ifsc_consts.svh"
module ifsc_instr_field_ctrl_bench;
  import ifsc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        intReq = 1'b0;
  logic        machineCheck = 1'b0;
  logic        powerFail = 1'b0;
  logic [1:0]  activeState;
  logic        charAscii;
  logic        irqOut;
  logic [3:0]  baseSel = 4'h0;
  logic [3:0]  idxSel = 4'h0;
  logic [31:0] baseData;
  logic [31:0] idxData;
  logic [31:0] rd;
  logic [2:0]  fmt;
  logic [23:0] ea;
  int          mismatches = 0;
  int          num_checks = 0;
  logic [15:0] vHi [6] = '{16'h1a12, 16'h5a3d, 16'h5a30, 16'h9012, 16'ha2ff, 16'hd2c3};
  logic [31:0] vLo [6] = '{32'h0, 32'hf010_0000, 32'h0123_0000, 32'h4abc_0000,
                           32'h7001_0000, 32'h5fff_3123};
  always #25 clk_sys = ~clk_sys;
  ifsc_instr_field_ctrl i_ifsc_instr_field_ctrl (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .intReq(intReq), .machineCheck(machineCheck), .powerFail(powerFail),
    .activeState(activeState), .charAscii(charAscii), .irqOut(irqOut));
  ifsc_gpr_model i_ifsc_gpr_model (
    .stateSel(activeState), .baseSel(baseSel), .idxSel(idxSel),
    .baseData(baseData), .idxData(idxData));
  ////////////////////////////////////////
  // verdict and end of run, shared by the main sequence, the watchdog and the bus timeout
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic hang;
    mismatches++;
    stop_test();
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpPin(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: pin %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // single transfer; waits on hready rather than assuming zero wait states
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    if (n >= 40) hang();
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdm(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rd & m, e);
  endtask
  // load an operand address and size, then read back address, size and flag
  task automatic align(input logic [31:0] v, input logic bad);
    wr(`IFSC_ADDR_OPADDR, v);
    tick(2);
    rdm(`IFSC_ADDR_OPADDR, 32'h07ff_ffff, {5'h0, bad, v[25:0]});
  endtask
  // raise an event line until the state moves, then drop it; k 3 fires two at once
  task automatic ev(input int k, input logic [1:0] exp);
    int n;
    intReq <= (k == 0 || k == 3);
    machineCheck <= (k == 1 || k == 3);
    powerFail <= (k == 2);
    n = 0;
    do begin @(posedge clk_sys); n++; end while (activeState !== exp && n < 20);
    intReq <= 1'b0;
    machineCheck <= 1'b0;
    powerFail <= 1'b0;
    tick(4);
    cmpPin(activeState, exp);
  endtask
  ////////////////////////////////////////
  // a hang anywhere ends the run as a failure
  initial begin
    tick(20000);
    hang();
  end
  initial begin
    tick(10);
    sys_rst <= 1'b0;
    tick(1);
    cmpPin(activeState, 2'b00);
    cmpPin({1'b0, charAscii}, 2'b00);
    cmpPin({1'b0, hresp}, 2'b00);
    rdm(`IFSC_ADDR_STATE, 32'h3, 32'h0);
    wr(32'h30, 32'hffff_ffff);
    rdm(32'h30, 32'hffff_ffff, 32'h0);
    wr(`IFSC_ADDR_CTRL, 32'h1);
    tick(2);
    cmpPin({1'b0, charAscii}, 2'b01);
    rdm(`IFSC_ADDR_CTRL, 32'h1, 32'h1);
    wr(`IFSC_ADDR_CTRL, 32'h0);
    tick(2);
    cmpPin({1'b0, charAscii}, 2'b00);
    // masked interrupt: status sets but the output stays low
    ev(0, 2'b11);
    cmpPin({1'b0, irqOut}, 2'b00);
    rdm(`IFSC_ADDR_IRQSTAT, 32'h1, 32'h1);
    rdm(`IFSC_ADDR_IRQSTAT, 32'h1, 32'h0);
    rdm(`IFSC_ADDR_STATE, 32'hf, 32'h3);
    wr(`IFSC_ADDR_IRQMASK, 32'h1);
    ev(3, 2'b10);
    tick(2);
    cmpPin({1'b0, irqOut}, 2'b01);
    rdm(`IFSC_ADDR_IRQSTAT, 32'h1, 32'h1);
    tick(2);
    cmpPin({1'b0, irqOut}, 2'b00);
    wr(`IFSC_ADDR_CTRL, 32'h8);
    tick(2);
    cmpPin(activeState, 2'b00);
    ev(2, 2'b10);
    wr(`IFSC_ADDR_CTRL, 32'ha);
    tick(2);
    cmpPin(activeState, 2'b01);
    ev(0, 2'b11);
    wr(`IFSC_ADDR_CTRL, 32'h8);
    tick(2);
    // at least one instruction of every format; register contents come from the model
    for (int i = 0; i < 6; i++) begin
      wr(`IFSC_ADDR_INSTR_HI, {16'h0, vHi[i]});
      wr(`IFSC_ADDR_INSTR_LO, vLo[i]);
      baseSel <= (vHi[i][15:14] == 2'b11) ? vLo[i][15:12] : vLo[i][31:28];
      idxSel <= vHi[i][3:0];
      tick(1);
      wr(`IFSC_ADDR_BASEVAL, baseData);
      wr(`IFSC_ADDR_INDEXVAL, idxData);
      tick(2);
      fmt = (vHi[i][15:14] == 2'b11) ? 3'd4 :
            (vHi[i][15:14] == 2'b10) ? (vHi[i][13] ? 3'd3 : 3'd2) : {1'b0, vHi[i][15:14]};
      // storage-storage addresses its second operand from the third halfword
      ea = ((baseSel != 4'h0) ? baseData[23:0] : 24'h0) +
           ((fmt == 3'd1 && idxSel != 4'h0) ? idxData[23:0] : 24'h0) +
           {12'h0, (fmt == 3'd4) ? vLo[i][11:0] : vLo[i][27:16]};
      rdm(`IFSC_ADDR_FIELDS0, 32'h7000_ff00, {1'b0, fmt, 12'h0, vHi[i][7:0], 8'h0});
      if (fmt != 3'd0)
        rdm(`IFSC_ADDR_EADDR, 32'h00ff_ffff, {8'h0, ea});
      if (fmt == 3'd4)
        rdm(`IFSC_ADDR_FIELDS1, 32'hffff_ffff, vLo[i]);
      else if (fmt == 3'd3)
        rdm(`IFSC_ADDR_FIELDS1, 32'hffff_0000, {vLo[i][31:16], 16'h0});
      else if (fmt != 3'd0)
        rdm(`IFSC_ADDR_FIELDS1, 32'h0000_ffff, {16'h0, vLo[i][31:16]});
    end
    // operand boundaries for every size, with the new-misalignment status bit
    align(32'h0100_0001, 1'b1);
    rdm(`IFSC_ADDR_IRQSTAT, 32'h2, 32'h2);
    align(32'h0100_0002, 1'b0);
    align(32'h0200_0006, 1'b1);
    align(32'h0200_0004, 1'b0);
    align(32'h0300_0004, 1'b1);
    align(32'h0300_0008, 1'b0);
    align(32'h0000_0003, 1'b0);
    rdm(`IFSC_ADDR_IRQSTAT, 32'h2, 32'h2);
    stop_test();
  end
endmodule
`default_nettype wire
